// *** rtl/flic_regs.vh ***
// Register offsets, field positions, reset values and vectors of the interrupt controller
`ifndef FLIC_REGS_VH
`define FLIC_REGS_VH

// ****************************************
// Register index; the bus byte address is four times it
// ****************************************
`define FLIC_OFS_ENABLE      8'ha8
`define FLIC_OFS_PRIO_LOW    8'hb8
`define FLIC_OFS_PRIO_HIGH   8'hb7
`define FLIC_OFS_CTRL        8'hc0
`define FLIC_OFS_STATUS      8'hc4
`define FLIC_OFS_INT_STAT    8'hc8
`define FLIC_OFS_INT_MASK    8'hcc

// ****************************************
// Register byte addresses, 10 bits
// ****************************************
`define FLIC_ADR_ENABLE      {`FLIC_OFS_ENABLE, 2'b00}
`define FLIC_ADR_PRIO_LOW    {`FLIC_OFS_PRIO_LOW, 2'b00}
`define FLIC_ADR_PRIO_HIGH   {`FLIC_OFS_PRIO_HIGH, 2'b00}
`define FLIC_ADR_CTRL        {`FLIC_OFS_CTRL, 2'b00}
`define FLIC_ADR_STATUS      {`FLIC_OFS_STATUS, 2'b00}
`define FLIC_ADR_INT_STAT    {`FLIC_OFS_INT_STAT, 2'b00}
`define FLIC_ADR_INT_MASK    {`FLIC_OFS_INT_MASK, 2'b00}

// ****************************************
// Fields
// ****************************************
`define FLIC_NSRC            7
`define FLIC_GLOBAL_BIT      7
`define FLIC_RSV_BIT         7
`define FLIC_IDLE_LEVEL      3'h4

// ****************************************
// Reset values
// ****************************************
`define FLIC_RST_ENABLE      8'h00
`define FLIC_RST_PRIO        7'h00
`define FLIC_RST_MASK        2'h0

// ****************************************
// Vector addresses, polling order index 0..6
// ****************************************
`define FLIC_VEC_EXT_A       16'h0003
`define FLIC_VEC_TIMER0      16'h000b
`define FLIC_VEC_EXT_B       16'h0013
`define FLIC_VEC_TIMER1      16'h001b
`define FLIC_VEC_SERIAL_A    16'h0023
`define FLIC_VEC_TIMER2      16'h002b
`define FLIC_VEC_SERIAL_B    16'h0033

`endif

// *** rtl/flic_sync.v ***
// Three-stage synchroniser with agreement filter for the external request pins
`timescale 1ns/100ps
module flic_sync
(
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Pin and clean level
  input  wire pin_in,
  output reg  level_out
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // Level changes only once stages two and three agree
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q      <= 1'b0;
      s2_q      <= 1'b0;
      s3_q      <= 1'b0;
      level_out <= 1'b0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
      begin
        level_out <= s3_q;
      end
    end
  end

endmodule

// *** rtl/flic_top.v ***
// Four-level seven-source interrupt controller with AXI4-Lite register access
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "flic_regs.vh"

module flic_top
(
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Request sources
  input  wire        ext_request_a_pin,
  input  wire        ext_request_b_pin,
  input  wire        timer0_ovf,
  input  wire        timer1_ovf,
  input  wire        timer2_ovf,
  input  wire        serial_a_req,
  input  wire        serial_b_req,
  // Core side
  output wire        irq_req,
  output reg  [15:0] irq_vector,
  output reg  [1:0]  irq_level,
  input  wire        irq_ack,
  input  wire        irq_return,
  // AXI4-Lite slave
  input  wire [9:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [9:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Interrupt to system
  output wire        irq_out
);

  // ****************************************
  // Vector lookup by polling index
  // ****************************************
  function [15:0] vec_of;
    input [2:0] idx;
    begin
      case (idx)
        3'h0:    vec_of = `FLIC_VEC_EXT_A;
        3'h1:    vec_of = `FLIC_VEC_TIMER0;
        3'h2:    vec_of = `FLIC_VEC_EXT_B;
        3'h3:    vec_of = `FLIC_VEC_TIMER1;
        3'h4:    vec_of = `FLIC_VEC_SERIAL_A;
        3'h5:    vec_of = `FLIC_VEC_TIMER2;
        default: vec_of = `FLIC_VEC_SERIAL_B;
      endcase
    end
  endfunction

  // Every mapped register, shared by the read and write decode
  function reg_hit;
    input [9:0] adr;
    begin
      reg_hit = (adr == `FLIC_ADR_ENABLE) || (adr == `FLIC_ADR_PRIO_LOW) || (adr == `FLIC_ADR_PRIO_HIGH)
                || (adr == `FLIC_ADR_CTRL) || (adr == `FLIC_ADR_STATUS) || (adr == `FLIC_ADR_INT_STAT)
                || (adr == `FLIC_ADR_INT_MASK);
    end
  endfunction

  // ****************************************
  // Registers and state
  // ****************************************
  reg  [7:0] int_enable_reg_q;
  reg  [6:0] priority_low_reg_q;
  reg  [6:0] priority_high_reg_q;
  reg  [3:0] in_service_q;
  reg  [1:0] int_stat_q;
  reg  [1:0] int_mask_q;
  reg        bus_irq_off_q;

  wire ext_a_lvl;
  wire ext_b_lvl;

  flic_sync u_sync_a
  (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (ext_request_a_pin),
    .level_out (ext_a_lvl)
  );

  flic_sync u_sync_b
  (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (ext_request_b_pin),
    .level_out (ext_b_lvl)
  );

  // Source vector in enable-register bit order
  wire [6:0] src_raw = {serial_b_req, timer2_ovf, serial_a_req, timer1_ovf,
                        ext_b_lvl, timer0_ovf, ext_a_lvl};

  wire       global_irq_enable = int_enable_reg_q[`FLIC_GLOBAL_BIT];
  wire [6:0] src_en = src_raw & int_enable_reg_q[6:0]
                      & {7{global_irq_enable}};

  // ****************************************
  // Arbitration
  // ****************************************
  reg  [2:0] win_idx;
  reg  [1:0] win_lvl;
  reg        win_any;
  reg  [1:0] lvl_i;
  integer    i;

  // Scan highest index down so the lowest polling index wins ties
  always @*
  begin
    win_idx = 3'h0;
    win_lvl = 2'h0;
    win_any = 1'b0;
    lvl_i   = 2'h0;
    for (i = `FLIC_NSRC - 1; i >= 0; i = i - 1)
    begin
      lvl_i = {priority_high_reg_q[i], priority_low_reg_q[i]};
      if (src_en[i] && (!win_any || lvl_i >= win_lvl))
      begin
        win_any = 1'b1;
        win_lvl = lvl_i;
        win_idx = i[2:0];
      end
    end
  end

  // Highest level currently in service, 4 means none
  reg [2:0] cur_lvl;
  always @*
  begin
    if (in_service_q[3])
      cur_lvl = 3'h3;
    else if (in_service_q[2])
      cur_lvl = 3'h2;
    else if (in_service_q[1])
      cur_lvl = 3'h1;
    else if (in_service_q[0])
      cur_lvl = 3'h0;
    else
      cur_lvl = `FLIC_IDLE_LEVEL;
  end

  // Strictly higher only; level 3 in service blocks all
  wire may_preempt = (cur_lvl == `FLIC_IDLE_LEVEL) || ({1'b0, win_lvl} > cur_lvl);
  assign irq_req = win_any && may_preempt && !bus_irq_off_q;

  // Vector and level held in flops for the core
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_vector <= 16'h0000;
      irq_level  <= 2'h0;
    end
    else
    begin
      irq_vector <= vec_of(win_idx);
      irq_level  <= win_lvl;
    end
  end

  // ****************************************
  // In-service tracking
  // ****************************************
  reg [3:0] in_service_d;
  always @*
  begin
    in_service_d = in_service_q;
    // Return releases only the highest active level
    if (irq_return && cur_lvl != `FLIC_IDLE_LEVEL)
      in_service_d[cur_lvl[1:0]] = 1'b0;
    // Ack honoured only while the request is really offered
    if (irq_ack && irq_req)
      in_service_d[irq_level] = 1'b1;
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
      in_service_q <= 4'h0;
    else
      in_service_q <= in_service_d;
  end

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  reg       aw_held_q;
  reg [9:0] aw_addr_q;
  reg       w_held_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;

  wire       do_write = aw_held_q && w_held_q;
  wire [7:0] wdat     = w_data_q[7:0];
  wire       wlane    = w_strb_q[0];

  // Interrupt events: bit 0 grant taken, bit 1 handler return
  wire [1:0] int_events = {irq_return & (cur_lvl != `FLIC_IDLE_LEVEL), irq_ack & irq_req};

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held_q           <= 1'b0;
      aw_addr_q           <= 10'h000;
      w_held_q            <= 1'b0;
      w_data_q            <= 32'h00000000;
      w_strb_q            <= 4'h0;
      s_axi_bvalid        <= 1'b0;
      s_axi_bresp         <= 2'h0;
      int_enable_reg_q    <= `FLIC_RST_ENABLE;
      priority_low_reg_q  <= `FLIC_RST_PRIO;
      priority_high_reg_q <= `FLIC_RST_PRIO;
      int_mask_q          <= `FLIC_RST_MASK;
      int_stat_q          <= 2'h0;
      bus_irq_off_q       <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      int_stat_q    <= int_stat_q | int_events;
      if (do_write)
      begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_hit(aw_addr_q) ? 2'h0 : 2'h2;
        if (wlane)
        begin
          if (aw_addr_q == `FLIC_ADR_ENABLE)
            int_enable_reg_q <= wdat;
          else if (aw_addr_q == `FLIC_ADR_PRIO_LOW)
            priority_low_reg_q <= wdat[6:0];
          else if (aw_addr_q == `FLIC_ADR_PRIO_HIGH)
            priority_high_reg_q <= wdat[6:0];
          else if (aw_addr_q == `FLIC_ADR_CTRL)
            bus_irq_off_q <= wdat[0];
          else if (aw_addr_q == `FLIC_ADR_INT_STAT)
            int_stat_q <= (int_stat_q & ~wdat[1:0]) | int_events;     // New events win over the clear
          else if (aw_addr_q == `FLIC_ADR_INT_MASK)
            int_mask_q <= wdat[1:0];
        end
      end
    end
  end

  assign irq_out = |(int_stat_q & int_mask_q);

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  reg [31:0] rd_word;
  always @*
  begin
    rd_word = 32'h00000000;
    if (s_axi_araddr == `FLIC_ADR_ENABLE)
      rd_word[7:0] = int_enable_reg_q;
    else if (s_axi_araddr == `FLIC_ADR_PRIO_LOW)
      rd_word[6:0] = priority_low_reg_q;
    else if (s_axi_araddr == `FLIC_ADR_PRIO_HIGH)
      rd_word[6:0] = priority_high_reg_q;
    else if (s_axi_araddr == `FLIC_ADR_CTRL)
      rd_word[0] = bus_irq_off_q;
    else if (s_axi_araddr == `FLIC_ADR_STATUS)
      rd_word[15:0] = {src_raw, 1'b0, in_service_q, cur_lvl, irq_req};
    else if (s_axi_araddr == `FLIC_ADR_INT_STAT)
      rd_word[1:0] = int_stat_q;
    else if (s_axi_araddr == `FLIC_ADR_INT_MASK)
      rd_word[1:0] = int_mask_q;
  end

  wire rd_hit = reg_hit(s_axi_araddr);

  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// *** tb/flic_core_model.sv ***
// Behavioural core that takes vectors and returns from handlers
`timescale 1ns/100ps
module flic_core_model
(
  // Clock, reset, bench control
  input wire        clk, rst, hold, do_ret,
  // Controller link
  input wire        irq_req,
  input wire [15:0] irq_vector,
  input wire [1:0]  irq_level,
  output reg        irq_ack, irq_return,
  // Last accepted request
  output reg [15:0] last_vec,
  output reg [1:0]  last_lvl
);
  reg seen_q;
  // Ack a cycle late: vector and level lag the winner
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      {seen_q, irq_ack, irq_return, last_vec, last_lvl} <= 21'h0;
    end
    else
    begin
      seen_q <= irq_req && !irq_ack;
      irq_ack <= irq_req && seen_q && !irq_ack && !hold;
      irq_return <= do_ret;
      if (irq_ack && irq_req)
        {last_vec, last_lvl} <= {irq_vector, irq_level};
    end
endmodule

// *** tb/flic_props.sv ***
// Port assertions for the interrupt controller
`timescale 1ns/100ps
module flic_props
(
  // Clock, reset, sources, core link
  input wire        clk, rst, ext_request_a_pin, ext_request_b_pin, timer0_ovf, timer1_ovf,
  input wire        timer2_ovf, serial_a_req, serial_b_req, irq_req, irq_ack,
  input wire [15:0] irq_vector,
  input wire [1:0]  irq_level,
  // Bus handshakes
  input wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
  input wire        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire [1:0]  s_axi_bresp,
  input wire [31:0] s_axi_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire [5:0] others = {timer2_ovf, serial_a_req, timer1_ovf, ext_request_b_pin, timer0_ovf, ext_request_a_pin};
  // ********
  // Sequences
  // ********
  // Six quiet cycles outlast the pin synchroniser
  sequence s_quiet; ({serial_b_req, others} == 7'h00)[*6]; endsequence
  sequence s_only_b; (others == 6'h00)[*6] ##0 (serial_b_req && irq_req); endsequence
  sequence s_top_ack; irq_ack && irq_req && irq_level == 2'h3; endsequence
  sequence s_wr_in; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  property p_quiet; s_quiet |-> !irq_req; endproperty
  property p_vec; irq_req |=> irq_vector[2:0] == 3'h3 && irq_vector[15:3] <= 13'h0006; endproperty
  property p_ser_b; s_only_b |=> irq_vector == 16'h0033; endproperty
  property p_top; s_top_ack |=> !irq_req [*4]; endproperty
  property p_wr; s_wr_in |-> ##2 s_axi_bvalid; endproperty
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_quiet: assert property (p_quiet)
    else $error("request with no source");
  a_vec: assert property (p_vec)
    else $error("vector off table");
  a_ser_b: assert property (p_ser_b)
    else $error("serial b vector wrong");
  a_top: assert property (p_top)
    else $error("top level preempted");
  a_wr: assert property (p_wr)
    else $error("write answer late");
  a_rd: assert property (p_rd)
    else $error("read answer late");
  a_bhold: assert property (p_bhold)
    else $error("write answer dropped");
  a_rhold: assert property (p_rhold)
    else $error("read answer dropped");
endmodule
bind flic_top flic_props i_flic_props (.*);

// *** tb/flic_top_tb_top.sv ***
// Testbench for the interrupt controller
`timescale 1ns/100ps
module flic_top_tb_top;
  reg         clk, rst, ext_request_a_pin, ext_request_b_pin, timer0_ovf, timer1_ovf, timer2_ovf;
  reg         serial_a_req, serial_b_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready, hold, do_ret;
  reg         s_axi_arvalid, s_axi_rready;
  reg  [9:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata, d;
  reg  [3:0]  s_axi_wstrb;
  wire        irq_req, irq_ack, irq_return, irq_out, s_axi_awready, s_axi_wready;
  wire        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [15:0] irq_vector, last_vec;
  wire [1:0]  irq_level, last_lvl, s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  reg  [1:0]  r, b;
  integer     err_total, tests_run, i;
  flic_top i_flic_top (.*);
  flic_core_model i_flic_core_model (.*);
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ********
  // Tasks
  // ********
  task close_out;
  begin
    if (err_total == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
  begin
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      err_total = err_total + 1;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  task wr(input [9:0] a, input [31:0] v);
    reg pa, pw;
  begin
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw)
    begin
      @(posedge clk);
      if (pa && s_axi_awready)
      begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready)
      begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge clk);
    s_axi_bready <= 1'b1;
    @(posedge clk);
    b = s_axi_bresp;
    s_axi_bready <= 1'b0;
  end
  endtask
  task rd(input [9:0] a);
  begin
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge clk);
    while (!s_axi_arready) @(posedge clk);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk);
    s_axi_rready <= 1'b1;
    @(posedge clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  end
  endtask
  task src(input [6:0] v);
  begin
    @(posedge clk);
    {serial_b_req, timer2_ovf, serial_a_req, timer1_ovf, ext_request_b_pin, timer0_ovf, ext_request_a_pin} <= v;
  end
  endtask
  task take(input string n, input [15:0] v, input [1:0] l);
    integer k;
  begin
    k = 0;
    @(posedge clk);
    while (!(irq_ack && irq_req) && k < 60)
    begin
      @(posedge clk);
      k = k + 1;
    end
    #1;
    chk(n, {14'h0, l, v}, {14'h0, last_lvl, last_vec});
    chk("take_wait", 0, k >= 60);
  end
  endtask
  // Let the pin synchroniser drain before the handler ends
  task ret;
  begin
    repeat (6) @(posedge clk);
    do_ret <= 1'b1;
    @(posedge clk);
    do_ret <= 1'b0;
  end
  endtask
  task quiet(input string n);
  begin
    repeat (8) @(posedge clk);
    chk(n, 0, irq_req);
  end
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total = err_total + 1;
    close_out;
  end
  initial
  begin
    rst = 1'b1;
    {err_total, tests_run, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    {ext_request_a_pin, ext_request_b_pin, timer0_ovf, timer1_ovf, timer2_ovf, serial_a_req, serial_b_req} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hold, do_ret} = 0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(10'h2a0); chk("enable", 0, d);
    rd(10'h2e0); chk("prio_low", 0, d);
    rd(10'h2dc); chk("prio_high", 0, d);
    rd(10'h010); chk("unmapped", 2, r);
    wr(10'h010, 32'h1); chk("wr_unmapped", 2, b);
    wr(10'h2a0, 32'h7f); chk("wr_ok", 0, b);
    src(7'h02); quiet("global");
    wr(10'h2a0, 32'hfd); quiet("single");
    wr(10'h2a0, 32'hff); take("t0", 16'h000b, 0);
    rd(10'h2a0); chk("enable", 32'hff, d);
    src(0); ret;
    for (i = 0; i < 7; i = i + 1)
    begin
      src(7'h01 << i);
      take("vector", 16'h0003 + 16'h0008 * i, 0);
      src(0);
      ret;
    end
    hold <= 1'b1;
    src(7'h7f); repeat (8) @(posedge clk); chk("pending", 1, irq_req);
    hold <= 1'b0;
    take("poll", 16'h0003, 0);
    src(0); ret;
    wr(10'h2e0, 32'h40); src(7'h7f); take("level", 16'h0033, 1);
    src(0); ret;
    wr(10'h2dc, 32'h20); wr(10'h2e0, 32'h60);
    rd(10'h2dc); chk("prio_high", 32'h20, d);
    rd(10'h2e0); chk("prio_low", 32'h60, d);
    src(7'h02); take("nest0", 16'h000b, 0);
    src(7'h0a); quiet("equal");
    src(7'h4a); take("nest1", 16'h0033, 1);
    src(7'h6a); take("nest3", 16'h002b, 3);
    src(7'h08); quiet("top");
    ret; ret; quiet("held");
    ret; take("resume", 16'h001b, 0);
    src(0); ret;
    wr(10'h2e0, 0); src(7'h20); take("lvl2", 16'h002b, 2);
    src(0); ret;
    wr(10'h300, 32'h1); src(7'h02); quiet("ctrl_off");
    wr(10'h300, 32'h0); take("ctrl_on", 16'h000b, 0);
    src(0); ret;
    rd(10'h310); chk("core_state", 32'h8, d);
    chk("irq_out", 0, irq_out);
    wr(10'h330, 32'h1); chk("irq_out", 1, irq_out);
    rd(10'h320); chk("status", 32'h3, d);
    wr(10'h320, 32'h3); chk("irq_out", 0, irq_out);
    close_out;
  end
endmodule
